// ==== pkg/apc_pkg.sv ====
// Purpose: Shared constants for the converter pin interface control block.
// Assumes: Sixteen data pins and three converter pairs.
// Notes:   Sync vector positions index the bundled, synchronised host pins.
package apc_pkg;
  localparam int WORD_W     = 16;  // Width of the shared data pins.
  localparam int PAIRS      = 3;   // Number of converter pairs.
  localparam int WORDS_PAIR = 2;   // Result words delivered per pair.
  localparam int FIFO_DEPTH = 16;  // Result buffer depth.
  // Positions inside the synchronised pin vector.
  localparam int P_CS   = 0;
  localparam int P_RD   = 1;
  localparam int P_WR   = 2;
  localparam int P_ST   = 3;       // Three start pins, 3..5.
  localparam int P_SCLK = 6;
  localparam int P_RNG  = 7;
  localparam int P_RST  = 8;
  localparam int P_SER  = 9;
  localparam int P_HWS  = 10;
  localparam int P_LSEL = 11;      // Three lane selects, 11..13.
  localparam int P_DAT  = 14;      // Sixteen data pins, 14..29.
  localparam int SYNC_W = 30;
  // Data pins that carry the serial lanes and the buffer control.
  localparam int PIN_LANE_A = 8;
  localparam int PIN_REFBUF = 14;
  // Control register fields.
  localparam int CTRL_PAIR = 0;    // Pair enables, bits 2..0.
  localparam int CTRL_RNG  = 3;    // Pair range bits, bits 5..3.
  localparam logic [WORD_W-1:0] CTRL_RESET = 16'h0000;
endpackage

// ==== verilog/apc_fifo.sv ====
// Purpose: Result buffer with valid/ready on both sides.
// Assumes: Single clock; flush empties it in one cycle.
// Notes:   Read data come from a register that tracks the next head word.
`timescale 1ns/1ps
module apc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("apc_fifo: DEPTH must be at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
    logic [WIDTH-1:0]            rdata;
    logic                        rdy;
    logic                        vld;
  } apc_fifo_state_type;

  apc_fifo_state_type q;
  apc_fifo_state_type n;
  logic               push;
  logic               pop;
  logic [AW-1:0]      rd_next;

  // Wrapping pointer step; depth need not be a power of two.
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // Next state; a write to the next head address is bypassed into the read register.
  always_comb begin
    n       = q;
    push    = in_valid & q.rdy;
    pop     = out_ready & q.vld;
    rd_next = pop ? step(q.rd) : q.rd;
    n.rd    = rd_next;
    if (push) begin
      n.mem[q.wr] = in_data;
      n.wr        = step(q.wr);
    end
    n.cnt   = CW'(q.cnt + CW'(push) - CW'(pop));
    n.rdata = (push && q.wr == rd_next) ? in_data : q.mem[rd_next];
    n.rdy   = (n.cnt != CW'(DEPTH));
    n.vld   = (n.cnt != '0);
    if (flush) begin
      n.wr  = '0;
      n.rd  = '0;
      n.cnt = '0;
      n.rdy = 1'b1;
      n.vld = 1'b0;
    end
  end

  // Single state register.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q     <= '0;
      q.rdy <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign in_ready  = q.rdy;
  assign out_valid = q.vld;
  assign out_data  = q.rdata;
endmodule

// ==== verilog/apc_pin_ctrl.sv ====
// Purpose: Pin behaviour of a six-channel simultaneous-sampling converter.
// Assumes: Host pins are asynchronous and pass two flip-flops first.
// Notes:   Results from the converter core queue in a 16-word buffer.
// Notes on behaviour
// [R1] Serial lane B select drives pin 9.
// [R2] Serial lane C select drives pin 10.
// [R3] Host grounds pin 11 in serial mode.
// [R4] Parallel read drives data while selected.
// [R5] Parallel write captures pins into control.
// [R6] Narrow variants pad upper bits with zero.
// [R7] Serial mode: pin 14 sets reference buffers.
// [R8] Software mode reset aborts, clears control.
// [R9] Hardware mode reset latches selection pins.
// [R10] Host pulses reset once after power-up.
// [R11] Start low in reset needs full pulse.
// [R12] Hardware mode reset only between conversions.
// [R13] Hardware mode range latched at busy fall.
// [R14] Software mode range from control bits.
// [R15] Host grounds pins 12, 13, 15 serially.
// [R16] Serial lane A select drives pin 8.
// [R17] Pair choice by pins or control register.
// [R18] Busy high until all results buffered.
`timescale 1ns/1ps
module apc_pin_ctrl
  import apc_pkg::*;
#(
  parameter int RESOLUTION = 16
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Host control pins
  input  wire logic                  chip_select_n,
  input  wire logic                  read_n,
  input  wire logic                  write_n,
  input  wire logic [2:0]            conversion_start_n,
  input  wire logic                  serial_clock,
  input  wire logic                  range_pin,
  input  wire logic                  reset_pin,
  input  wire logic                  serial_parallel_select,
  input  wire logic                  hw_sw_select,
  input  wire logic [2:0]            lane_select,
  // Shared data pins and the busy output
  input  wire logic [apc_pkg::WORD_W-1:0] data_in,
  output logic [apc_pkg::WORD_W-1:0] data_out,
  output logic [apc_pkg::WORD_W-1:0] data_oe_n,
  output logic                       busy,
  // Converter core side
  input  wire logic                  sample_valid,
  input  wire logic [apc_pkg::WORD_W-1:0] sample_data,
  output logic                       sample_ready,
  output logic                       convert_start,
  output logic [2:0]                 convert_pairs,
  output logic [2:0]                 range_select,
  output logic                       reference_buffer_enable
);
  import apc_pkg::*;

  // Idle levels of the host pins: strobes, start pins and serial clock high, all else low.
  // Resetting the stages to these levels avoids a false reset-pin pulse and a stray buffer enable.
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 30'h0000007F;

  initial begin
    if (RESOLUTION != 16 && RESOLUTION != 14 && RESOLUTION != 12) $error("apc_pin_ctrl: bad RESOLUTION");
  end

  typedef enum logic [2:0] {
    SER_IDLE  = 3'b001,
    SER_LOAD  = 3'b010,
    SER_SHIFT = 3'b100
  } apc_ser_type;

  typedef struct packed {
    logic [SYNC_W-1:0]           s1;
    logic [SYNC_W-1:0]           s2;
    logic [SYNC_W-1:0]           prev;
    logic [WORD_W-1:0]           ctrl;
    logic                        armed;
    logic                        busy;
    logic                        conv_start;
    logic [2:0]                  pairs;
    logic [2:0]                  need;
    logic                        range_hw;
    logic [2:0]                  range_out;
    logic                        refbuf;
    logic [WORD_W-1:0]           dout;
    logic [WORD_W-1:0]           doe_n;
    apc_ser_type                 sst;
    logic [1:0]                  lane;
    logic [PAIRS-1:0][WORD_W-1:0] sh;
  } apc_state_type;

  apc_state_type     q;
  apc_state_type     n;
  logic [SYNC_W-1:0] pins;
  logic              fifo_valid;
  logic              fifo_ready;
  logic [WORD_W-1:0] fifo_data;
  logic              pop;
  logic              push;
  logic              flush;
  logic              cs;
  logic              rd_act;
  logic              ser;
  logic              sw;
  logic [2:0]        st_fall;
  logic [2:0]        st_rise;
  logic [2:0]        trig;
  logic [2:0]        sel;

  // Upper bits beyond the variant's resolution always read as zero.
  function automatic logic [WORD_W-1:0] pad(input logic [WORD_W-1:0] w);
    pad = w & WORD_W'((17'h1_0000 >> (WORD_W - RESOLUTION)) - 17'h0_0001);
  endfunction

  // Two result words per enabled pair.
  function automatic logic [2:0] words(input logic [2:0] p);
    words = 3'(WORDS_PAIR * (int'(p[0]) + int'(p[1]) + int'(p[2])));
  endfunction

  assign pins = {data_in, lane_select, hw_sw_select, serial_parallel_select, reset_pin,
                 range_pin, serial_clock, conversion_start_n, write_n, read_n, chip_select_n};

  // Decoded views of the synchronised pins; the second stage is read, and the start edges also compare it with prev.
  assign cs      = ~q.s2[P_CS];
  assign rd_act  = cs & ~q.s2[P_RD];
  assign ser     = q.s2[P_SER];
  assign sw      = q.s2[P_HWS];
  assign sel     = q.s2[P_LSEL +: 3];
  assign st_fall = q.prev[P_ST +: 3] & ~q.s2[P_ST +: 3];
  assign st_rise = ~q.prev[P_ST +: 3] & q.s2[P_ST +: 3];
  assign trig    = sw ? 3'b001 : 3'b111; // R17
  assign push    = sample_valid & q.busy;
  assign flush   = q.s2[P_RST];

  // Whole next-state function of the block.
  always_comb begin
    n            = q;
    pop          = 1'b0;
    n.s1         = pins;
    n.s2         = q.s1;
    n.prev       = q.s2;
    n.conv_start = 1'b0;
    if (q.s2[P_RST]) begin
      n.busy  = 1'b0; // R8
      n.armed = 1'b0; // R11
      n.need  = '0;
      n.sst   = SER_IDLE;
      if (sw) begin
        n.ctrl = CTRL_RESET; // R8
      end else begin
        n.range_hw = q.s2[P_RNG]; // R9
      end
    end else begin
      // A start must fall after reset before its rise can launch a conversion.
      if (|(st_fall & trig)) begin
        n.armed = 1'b1; // R11
      end
      if (!q.busy && q.armed && |(st_rise & trig)) begin
        n.pairs      = sw ? q.ctrl[CTRL_PAIR +: 3] : st_rise; // R17
        n.need       = words(n.pairs);
        n.busy       = (n.pairs != 3'b000); // R18
        n.conv_start = n.busy;
        n.armed      = 1'b0;
      end
      if (q.busy && push && fifo_ready) begin
        n.need = 3'(q.need - 3'd1);
        if (q.need == 3'd1) begin
          n.busy = 1'b0; // R18
          if (!sw) begin
            n.range_hw = q.s2[P_RNG]; // R13
          end
        end
      end
      // Control capture at the end of a parallel write strobe.
      if (!ser && cs && !q.prev[P_WR] && q.s2[P_WR]) begin
        n.ctrl = q.s2[P_DAT +: WORD_W]; // R5
      end
    end
    // The range seen by the core only changes between conversions.
    if (!q.busy) begin
      n.range_out = sw ? q.ctrl[CTRL_RNG +: 3] : {3{q.range_hw}}; // R14
    end
    if (ser) begin
      n.refbuf = q.s2[P_DAT + PIN_REFBUF]; // R7
    end
    // Parallel read: one buffered word per read strobe.
    n.doe_n = '1;
    if (!ser) begin
      if (rd_act && !(~q.prev[P_CS] & ~q.prev[P_RD]) && fifo_valid) begin
        pop    = 1'b1;
        n.dout = pad(fifo_data); // R6
      end
      if (rd_act) begin
        n.doe_n = '0; // R4
      end
    end
    // Serial frame: load one word per selected lane, then shift on clock falls.
    case (q.sst)
      SER_IDLE: begin
        if (ser && cs && q.prev[P_CS]) begin
          n.sst  = SER_LOAD;
          n.lane = 2'd0;
        end
      end
      SER_LOAD: begin
        if (sel[q.lane] && fifo_valid) begin
          pop           = 1'b1;
          n.sh[q.lane]  = pad(fifo_data); // R6
        end else begin
          n.sh[q.lane]  = '0;
        end
        n.lane = 2'(q.lane + 2'd1);
        if (q.lane == 2'd2) begin
          n.sst = SER_SHIFT;
        end
      end
      SER_SHIFT: begin
        if (q.prev[P_SCLK] && !q.s2[P_SCLK]) begin
          for (int i = 0; i < PAIRS; i++) begin
            n.sh[i] = {q.sh[i][WORD_W-2:0], 1'b0};
          end
        end
        if (!cs || !ser) begin
          n.sst = SER_IDLE;
        end
      end
      default: begin
        n.sst = SER_IDLE;
      end
    endcase
    if (ser) begin
      for (int i = 0; i < PAIRS; i++) begin
        n.dout[PIN_LANE_A + i]  = n.sh[i][WORD_W-1];
        n.doe_n[PIN_LANE_A + i] = ~(sel[i] & cs); // R16 R1 R2
      end
    end
    if (q.s2[P_RST]) begin
      pop = 1'b0;
    end
  end

  // Single state register; the three-state enables idle high.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q       <= '0;
      q.ctrl  <= CTRL_RESET;
      q.doe_n <= '1;
      q.sst   <= SER_IDLE;
      q.s1    <= SYNC_IDLE;
      q.s2    <= SYNC_IDLE;
      q.prev  <= SYNC_IDLE;
    end else begin
      q <= n;
    end
  end

  apc_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .flush     (flush),
    .in_valid  (push),
    .in_data   (sample_data),
    .in_ready  (fifo_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (pop)
  );

  assign data_out                = q.dout;
  assign data_oe_n               = q.doe_n;
  assign busy                    = q.busy;
  assign sample_ready            = fifo_ready;
  assign convert_start           = q.conv_start;
  assign convert_pairs           = q.pairs;
  assign range_select            = q.range_out;
  assign reference_buffer_enable = q.refbuf;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_LANE_A: assert property (ser && sel[0] && cs |=> !data_oe_n[8]) else $error("lane A not driven"); // R16
  AST_LANE_B: assert property (ser && sel[1] && cs |=> !data_oe_n[9]) else $error("lane B not driven"); // R1
  AST_LANE_C: assert property (ser && sel[2] && cs |=> !data_oe_n[10]) else $error("lane C not driven"); // R2
  AST_PAR_RD: assert property (!ser && rd_act |=> data_oe_n == '0) else $error("read not driven"); // R4
  AST_PAR_OFF: assert property (!ser && !rd_act |=> data_oe_n == '1) else $error("pins not released"); // R4
  AST_WRITE: assert property (!ser && cs && !q.prev[P_WR] && q.s2[P_WR] && !flush
    |=> q.ctrl == $past(q.s2[P_DAT +: WORD_W])) else $error("write not captured"); // R5
  AST_PAD: assert property ((data_out & ~pad(data_out)) == '0 || ser) else $error("upper bits not zero"); // R6
  AST_REFBUF: assert property (ser |=> reference_buffer_enable == $past(q.s2[P_DAT + PIN_REFBUF]))
    else $error("buffer enable wrong"); // R7
  AST_RST_SW: assert property (flush && sw |=> q.ctrl == CTRL_RESET && !busy) else $error("reset no clear"); // R8
  AST_RST_HW: assert property (flush && !sw |=> q.range_hw == $past(q.s2[P_RNG])) else $error("reset no latch"); // R9
  AST_ARM: assert property (!q.armed |=> !convert_start) else $error("start without full pulse"); // R11
  AST_RNG_HW: assert property (!sw && !flush ##1 $fell(busy) |-> q.range_hw == $past(q.s2[P_RNG]))
    else $error("range not latched"); // R13
  AST_RNG_SW: assert property (sw && !busy |=> range_select == $past(q.ctrl[CTRL_RNG +: 3]))
    else $error("range not from control"); // R14
  AST_BUSY: assert property (convert_start |-> busy && !$past(busy)) else $error("busy low at start"); // R18
  AST_BUSY_HOLD: assert property (busy && !flush && !push |=> busy) else $error("busy fell early"); // R18

  COV_CONV: cover property (convert_start ##[1:200] $fell(busy));
  COV_PAR_READ: cover property (!ser && rd_act ##1 !data_oe_n[0]);
  COV_SER_FRAME: cover property (q.sst == SER_LOAD ##3 q.sst == SER_SHIFT);
endmodule

// ==== bench/apc_core_model.sv ====
// Purpose: Behavioural converter core that feeds result words to the pin block.
// Assumes: Two words per enabled pair, word n is 16'hFA50 plus n.
// Notes:   GAP sets how slowly words arrive; released data shows the inverse.
`timescale 1ns/1ps
module apc_core_model #(
  parameter int GAP = 2
) (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // Launch from the pin block
  input  wire logic                       convert_start,
  input  wire logic [2:0]                 convert_pairs,
  // Result hand-over
  input  wire logic                       sample_ready,
  output logic                            sample_valid,
  output logic [apc_pkg::WORD_W-1:0]      sample_data
);
  import apc_pkg::*;
  int unsigned n;
  int unsigned left;

  // Words are held until accepted, so a stalled buffer never loses one.
  initial begin
    sample_valid = 1'b0;
    sample_data  = 16'h0000;
    n            = 0;
    forever begin
      @(posedge clock);
      if (convert_start && !rst) begin
        left = 2 * $countones(convert_pairs);
        while (left > 0) begin
          repeat (GAP) @(posedge clock);
          sample_valid <= 1'b1;
          sample_data  <= 16'hFA50 + n[15:0];
          do @(posedge clock); while (sample_ready !== 1'b1);
          sample_valid <= 1'b0;
          sample_data  <= ~(16'hFA50 + n[15:0]);
          n++;
          left--;
        end
      end
    end
  end
endmodule

// ==== bench/apc_pin_ctrl_tb.sv ====
// Purpose: Self-checking bench for the converter pin interface block.
// Assumes: 12-bit variant, host pins driven on the falling clock edge.
// Notes:   Each scenario task drives the pins and judges the answer itself.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((exp) !== (got)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module apc_pin_ctrl_tb;
  import apc_pkg::*;
  localparam int                RES  = 12;
  localparam logic [WORD_W-1:0] MASK = 16'hFFFF >> (WORD_W - RES);
  logic              clock, rst, chip_select_n, read_n, write_n, serial_clock;
  logic              range_pin, reset_pin, serial_parallel_select, hw_sw_select;
  logic [2:0]        conversion_start_n, lane_select, convert_pairs, range_select;
  logic [WORD_W-1:0] data_in, data_out, data_oe_n, sample_data;
  logic              busy, sample_valid, sample_ready, convert_start, reference_buffer_enable;
  int                failures, checks, nxt;

  apc_pin_ctrl #(.RESOLUTION(RES)) i_apc_pin_ctrl (
    .clock(clock), .rst(rst), .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n),
    .conversion_start_n(conversion_start_n), .serial_clock(serial_clock), .range_pin(range_pin),
    .reset_pin(reset_pin), .serial_parallel_select(serial_parallel_select),
    .hw_sw_select(hw_sw_select), .lane_select(lane_select), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .busy(busy), .sample_valid(sample_valid), .sample_data(sample_data),
    .sample_ready(sample_ready), .convert_start(convert_start), .convert_pairs(convert_pairs),
    .range_select(range_select), .reference_buffer_enable(reference_buffer_enable));
  apc_core_model #(.GAP(3)) i_apc_core_model (
    .clock(clock), .rst(rst), .convert_start(convert_start), .convert_pairs(convert_pairs),
    .sample_ready(sample_ready), .sample_valid(sample_valid), .sample_data(sample_data));

  // Free-running system clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask

  // Expected padded result word in delivery order.
  function automatic logic [WORD_W-1:0] exp_word(input int k);
    return (16'hFA50 + k[15:0]) & MASK;
  endfunction

  task automatic write_ctrl(input logic [WORD_W-1:0] v);
    data_in       = v;
    chip_select_n = 1'b0;
    write_n       = 1'b0;
    cyc(5);
    write_n       = 1'b1;
    cyc(4);
    chip_select_n = 1'b1;
    cyc(3);
  endtask

  task automatic read_word();
    chip_select_n = 1'b0;
    read_n        = 1'b0;
    cyc(5);
    `CHK("data_oe_n read", 16'h0000, data_oe_n)
    `CHK("data_out read", exp_word(nxt), data_out)
    nxt++;
    read_n        = 1'b1;
    chip_select_n = 1'b1;
    cyc(5);
    `CHK("data_oe_n idle", 16'hFFFF, data_oe_n)
  endtask

  // Full fall-then-rise on the chosen start pins, then wait for the launch.
  task automatic start_conv(input logic [2:0] pins, input logic [2:0] pairs, input bit go);
    int k;
    conversion_start_n = ~pins;
    cyc(5);
    conversion_start_n = 3'b111;
    for (k = 0; k < 12 && convert_start !== 1'b1; k++) @(negedge clock);
    `CHK("convert_start", go, convert_start)
    if (go) begin
      `CHK("convert_pairs", pairs, convert_pairs)
      `CHK("busy at launch", 1'b1, busy)
      for (k = 0; k < 300 && busy !== 1'b0; k++) @(negedge clock);
      if (k == 300) begin
        failures++;
        end_of_test();
      end
    end else begin
      `CHK("busy refused", 1'b0, busy)
    end
  endtask

  task automatic sw_scenario();
    hw_sw_select       = 1'b1;
    write_ctrl(16'h0009);
    conversion_start_n = 3'b110;
    reset_pin          = 1'b1;
    cyc(10);
    reset_pin          = 1'b0;
    cyc(5);
    conversion_start_n = 3'b111;
    cyc(12);
    `CHK("busy no fall", 1'b0, busy)
    start_conv(3'b001, 3'b000, 1'b0);
    write_ctrl(16'h0009);
    start_conv(3'b001, 3'b001, 1'b1);
    `CHK("range sw", 3'b001, range_select)
    read_word();
    read_word();
  endtask

  task automatic hw_scenario();
    hw_sw_select = 1'b0;
    range_pin    = 1'b0;
    reset_pin    = 1'b1;
    cyc(10);
    `CHK("range hw reset", 3'b000, range_select)
    reset_pin    = 1'b0;
    range_pin    = 1'b1;
    cyc(5);
    start_conv(3'b110, 3'b110, 1'b1);
    cyc(3);
    `CHK("range busy fall", 3'b111, range_select)
    repeat (4) read_word();
  endtask

  task automatic serial_scenario();
    logic [WORD_W-1:0] wa;
    logic [WORD_W-1:0] wb;
    wa                     = exp_word(nxt);
    wb                     = exp_word(nxt + 1);
    serial_parallel_select = 1'b1;
    lane_select            = 3'b011;
    data_in                = 16'h0000;
    cyc(5);
    `CHK("refbuf off", 1'b0, reference_buffer_enable)
    data_in                = 16'h4000;
    cyc(5);
    `CHK("refbuf on", 1'b1, reference_buffer_enable)
    start_conv(3'b001, 3'b001, 1'b1);
    chip_select_n          = 1'b0;
    cyc(8);
    `CHK("serial oe", 16'hFCFF, data_oe_n)
    `CHK("serial msb", {wb[15], wa[15]}, data_out[9:8])
    repeat (4) begin
      serial_clock = 1'b0;
      #80;
      serial_clock = 1'b1;
      #80;
    end
    cyc(3);
    `CHK("serial bit", {wb[11], wa[11]}, data_out[9:8])
    chip_select_n          = 1'b1;
    cyc(5);
    `CHK("serial idle oe", 16'hFFFF, data_oe_n)
    lane_select            = 3'b100;
    chip_select_n          = 1'b0;
    cyc(8);
    `CHK("lane c oe", 16'hFBFF, data_oe_n)
    chip_select_n          = 1'b1;
    cyc(5);
  endtask

  // Reset, then the scenarios in order.
  initial begin
    {rst, chip_select_n, read_n, write_n, serial_clock} = 5'h1F;
    {range_pin, reset_pin, serial_parallel_select, hw_sw_select} = 4'h0;
    conversion_start_n = 3'b111;
    lane_select        = 3'b000;
    data_in            = 16'h0000;
    failures           = 0;
    checks             = 0;
    nxt                = 0;
    cyc(12);
    rst = 1'b0;
    cyc(4);
    `CHK("oe after reset", 16'hFFFF, data_oe_n)
    `CHK("busy after reset", 1'b0, busy)
    sw_scenario();
    hw_scenario();
    serial_scenario();
    end_of_test();
  end
endmodule
